// [core/smp_pkg.sv]
// Constants and types shared by the serial port and its rate generator.
package smp_pkg;

  // ----------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] SMP_IDX_CTL = 6'h10;
  localparam logic [5:0] SMP_IDX_STS = 6'h11;
  localparam logic [5:0] SMP_IDX_DAT = 6'h12;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int SMP_CTL_RXIE = 7;
  localparam int SMP_CTL_MST = 5;
  localparam int SMP_CTL_CLOCK_POLARITY_BIT = 4;
  localparam int SMP_CTL_CLOCK_PHASE_BIT = 3;
  localparam int SMP_CTL_EN = 1;
  localparam int SMP_CTL_TXIE = 0;
  localparam logic [7:0] SMP_CTL_MASK = 8'hBB;
  localparam logic [7:0] SMP_CTL_RST = 8'h28;

  // ----------------------------------------------------------------
  // Status and control register fields
  // ----------------------------------------------------------------
  localparam int SMP_STS_RXF = 7;
  localparam int SMP_STS_ERROR_INT_ENABLE = 6;
  localparam int SMP_STS_OVR = 5;
  localparam int SMP_STS_MODE_FAULT_FLAG = 4;
  localparam int SMP_STS_TXE = 3;
  localparam int SMP_STS_MODE_FAULT_ENABLE = 2;
  localparam int SMP_STS_RATE_HI = 1;
  localparam int SMP_STS_RATE_LO = 0;

  // ----------------------------------------------------------------
  // Shift timing
  // ----------------------------------------------------------------
  localparam logic [3:0] SMP_EDGE_LAST = 4'hF;
  localparam logic [2:0] SMP_BIT1_SAMPLE = 3'h6;
  localparam logic [1:0] SMP_RATE_RATE_BY_TWO = 2'h0;
  localparam logic [1:0] SMP_RATE_DIV8 = 2'h1;
  localparam logic [1:0] SMP_RATE_DIV32 = 2'h2;
  localparam logic [6:0] SMP_HALF_RATE_BY_TWO = 7'h01;
  localparam logic [6:0] SMP_HALF_DIV8 = 7'h04;
  localparam logic [6:0] SMP_HALF_DIV32 = 7'h10;
  localparam logic [6:0] SMP_HALF_RATE_BY_ONETWENTYEIGHT = 7'h40;

  typedef enum logic [0:0] {
    SMP_IDLE = 1'b0,
    SMP_SHIFT = 1'b1
  } smp_state_t;

  // Bus cycles per half bit for each rate setting.
  function automatic logic [6:0] smp_half(input logic [1:0] rate);
    return (rate == SMP_RATE_RATE_BY_TWO) ? SMP_HALF_RATE_BY_TWO :
           (rate == SMP_RATE_DIV8) ? SMP_HALF_DIV8 :
           (rate == SMP_RATE_DIV32) ? SMP_HALF_DIV32 : SMP_HALF_RATE_BY_ONETWENTYEIGHT;
  endfunction

endpackage

// [core/smp_rate_if.sv]
// Link between the port and its master rate generator.
`timescale 1ns/1ps
`default_nettype none
interface smp_rate_if;
  logic run;
  logic [1:0] rate;
  logic tick;
  modport gen (input run, input rate, output tick);
  modport user (output run, output rate, input tick);
endinterface
`default_nettype wire

// [core/smp_baud_gen.sv]
// Free-running master rate generator giving one tick per half bit.
`timescale 1ns/1ps
`default_nettype none
module smp_baud_gen
  import smp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Rate link
  smp_rate_if.gen rif
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  wire logic [6:0] half_last = smp_half(rif.rate) - 7'h01;

  // Counter is cleared and held at zero while the port is not a running master, to save power.
  assign rif.tick = rif.run && (cnt_r == half_last);
  assign cnt_nxt = (!rif.run || rif.tick) ? 7'h00 : cnt_r + 7'h01;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_r <= 7'h00;
    end else if (i_ce) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// [core/smp_port.sv]
// Serial port, master or slave, with a Wishbone register slave.
// Function
// - Master-select bit one means master, else slave
// - Master data write launches transfer, sets empty
// - Master shifts in while shifting out
// - Rate bits set master bit clock
// - End of transfer loads receive data, sets full
// - Full clears on status then data read
// - Data write clears transmit interrupt enable
// - Slave never drives serial clock pin
// - Slave full byte sets receive full
// - Slave accepts clock up to half bus rate
// - Slave byte written early goes next transfer
// - Write during transfer waits for its end
// - Slave starts on select fall or edge
// - Polarity sets idle level, phase sets format
// - Slave drives MISO only while selected
// - Phase zero: MSB on select fall, retoggle
// - Phase one: first edge starts, select may stay
// - Late read at bit one sets overflow, discards
// - Master select low: fault, disable, empty, reset
// - Master start within one bit time
// - Fault clears by status read, control write
`timescale 1ns/1ps
`default_nettype none
module smp_port
  import smp_pkg::*;
(
  // Clock, reset and freeze
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Serial clock pin
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  // Master out, slave in
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  // Master in, slave out
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  // Slave select
  input wire logic i_ss_n
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] ctl_r;
  logic error_int_enable_r, mode_fault_enable_r;
  logic [1:0] rate_r;
  logic rxf_r, ovr_r, mode_fault_flag_r, txe_r;
  logic rarm_r, marm_r, disc_r;
  logic [7:0] txbuf_r, sh_r, rsh_r, rxd_r;
  logic [3:0] ecnt_r;
  logic sck_r, ssp_r, sckp_r;
  smp_state_t state_r;

  smp_rate_if rif ();

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic req = i_wb_cyc && i_wb_stb;
  wire logic acc = req && ack_r;
  wire logic hit_ctl = i_wb_adr[7:2] == SMP_IDX_CTL;
  wire logic hit_sts = i_wb_adr[7:2] == SMP_IDX_STS;
  wire logic hit_dat = i_wb_adr[7:2] == SMP_IDX_DAT;
  wire logic wr_lo = acc && i_wb_we && i_wb_sel[0];
  wire logic wr_ctl = wr_lo && hit_ctl;
  wire logic wr_sts = wr_lo && hit_sts;
  wire logic wr_dat = wr_lo && hit_dat;
  wire logic rd_sts = acc && !i_wb_we && hit_sts;
  wire logic rd_dat = acc && !i_wb_we && hit_dat;

  wire logic [7:0] sts_val = {rxf_r, error_int_enable_r, ovr_r, mode_fault_flag_r, txe_r, mode_fault_enable_r, rate_r};
  wire logic [7:0] rd_byte = hit_ctl ? ctl_r : hit_sts ? sts_val : hit_dat ? rxd_r : 8'h00;

  // ----------------------------------------------------------------
  // Mode and pin events
  // ----------------------------------------------------------------
  wire logic mst = ctl_r[SMP_CTL_MST];
  wire logic clock_polarity_bit = ctl_r[SMP_CTL_CLOCK_POLARITY_BIT];
  wire logic clock_phase_bit = ctl_r[SMP_CTL_CLOCK_PHASE_BIT];
  wire logic en = ctl_r[SMP_CTL_EN];
  wire logic act = state_r == SMP_SHIFT;

  // Slave clock is sampled at the bus clock, so each level must last one bus cycle.
  wire logic sck_act = i_sck ^ clock_polarity_bit;
  wire logic s_lead = sck_act && !sckp_r;
  wire logic s_trail = !sck_act && sckp_r;
  wire logic ss_fall = ssp_r && !i_ss_n;
  wire logic ss_rise = !ssp_r && i_ss_n;

  // Only the clock this port listens to in its mode can advance a transfer.
  wire logic m_edge = act && mst && rif.tick;
  wire logic s_edge = act && !mst && !i_ss_n && (s_lead || s_trail);
  wire logic edge_ev = m_edge || s_edge;

  wire logic m_start = mst && en && !act && !txe_r && rif.tick;
  wire logic s_start = !mst && en && !act &&
                       (clock_phase_bit ? (!i_ss_n && s_lead) : ss_fall);
  wire logic start = m_start || s_start;

  // Phase zero samples on leading edges, phase one on trailing edges.
  wire logic sample_ev = edge_ev && (ecnt_r[0] == clock_phase_bit);
  wire logic shift_ev = edge_ev && (ecnt_r[0] != clock_phase_bit) &&
                        (ecnt_r != 4'h0) && (ecnt_r != SMP_EDGE_LAST);
  wire logic done = edge_ev && (ecnt_r == SMP_EDGE_LAST);
  wire logic bit1_ev = sample_ev && (ecnt_r[3:1] == SMP_BIT1_SAMPLE);
  wire logic din = mst ? i_miso : i_mosi;
  wire logic [7:0] rx_next = sample_ev ? {rsh_r[6:0], din} : rsh_r;

  // ----------------------------------------------------------------
  // Faults
  // ----------------------------------------------------------------
  wire logic m_fault = mode_fault_enable_r && mst && en && ss_fall;
  wire logic s_abort = !mst && act && i_ss_n;
  wire logic s_fault = mode_fault_enable_r && s_abort && ss_rise;
  wire logic mode_fault_flag_cond = mode_fault_enable_r && ((mst && !i_ss_n) || s_abort);
  wire logic abort = !en || m_fault || s_abort;

  wire logic rxf_set = done && !disc_r;
  wire logic ovr_set = bit1_ev && rxf_r;
  wire logic txe_set = (start && !txe_r) || m_fault;

  assign rif.run = mst && en;
  assign rif.rate = rate_r;

  smp_baud_gen u_baud (
    .i_clk (i_clk),
    .i_resetn (i_resetn),
    .i_ce (i_ce),
    .rif (rif)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_wb_ack = ack_r;
  assign o_wb_dat = dat_r;
  assign o_sck = sck_r;
  assign o_sck_oe = mst && en;
  assign o_mosi = sh_r[7];
  assign o_mosi_oe = mst && en;
  assign o_miso = sh_r[7];
  assign o_miso_oe = !mst && en && !i_ss_n;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Read data is latched with the ack so a flag change during the ack cycle cannot tear it.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (i_ce) begin
      ack_r <= req && !ack_r;
      if (req && !ack_r) begin
        dat_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctl_r <= SMP_CTL_RST;
      error_int_enable_r <= 1'b0;
      mode_fault_enable_r <= 1'b0;
      rate_r <= SMP_RATE_RATE_BY_TWO;
    end else if (i_ce) begin
      if (wr_ctl) begin
        ctl_r <= i_wb_dat[7:0] & SMP_CTL_MASK;
      end
      if (wr_dat) begin
        ctl_r[SMP_CTL_TXIE] <= 1'b0;
      end
      if (m_fault) begin
        ctl_r[SMP_CTL_EN] <= 1'b0;
      end
      if (wr_sts) begin
        error_int_enable_r <= i_wb_dat[SMP_STS_ERROR_INT_ENABLE];
        mode_fault_enable_r <= i_wb_dat[SMP_STS_MODE_FAULT_ENABLE];
        rate_r <= i_wb_dat[SMP_STS_RATE_HI:SMP_STS_RATE_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A hardware set in the same cycle as a software clear wins for the full, overflow and fault flags.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rxf_r <= 1'b0;
      ovr_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      rarm_r <= 1'b0;
      marm_r <= 1'b0;
    end else if (i_ce) begin
      rxf_r <= rxf_set || (rxf_r && !(rd_dat && rarm_r));
      ovr_r <= ovr_set || (ovr_r && !(rd_dat && rarm_r));
      mode_fault_flag_r <= m_fault || s_fault ||
                (mode_fault_flag_r && !(wr_ctl && marm_r && !mode_fault_flag_cond));
      rarm_r <= rd_sts || (rarm_r && !rd_dat);
      marm_r <= (rd_sts && mode_fault_flag_r && !mode_fault_flag_cond) || (marm_r && !wr_ctl && !mode_fault_flag_cond);
    end
  end

  // A new byte in the buffer outranks the load of the old one in the same cycle.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      txe_r <= 1'b1;
      txbuf_r <= 8'h00;
    end else if (i_ce) begin
      if (wr_dat) begin
        txbuf_r <= i_wb_dat[7:0];
        txe_r <= 1'b0;
      end else if (txe_set) begin
        txe_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_r <= SMP_IDLE;
      ecnt_r <= 4'h0;
    end else if (i_ce) begin
      if (abort) begin
        state_r <= SMP_IDLE;
        ecnt_r <= 4'h0;
      end else begin
        unique case (state_r)
          SMP_IDLE: begin
            if (start) begin
              state_r <= SMP_SHIFT;
              // A phase-one slave starts on its first edge, so that edge is already spent.
              ecnt_r <= (clock_phase_bit && !mst) ? 4'h1 : 4'h0;
            end
          end
          SMP_SHIFT: begin
            if (done) begin
              state_r <= SMP_IDLE;
              ecnt_r <= 4'h0;
            end else if (edge_ev) begin
              ecnt_r <= ecnt_r + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // Without a fresh byte the slave resends what its shift register holds.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sh_r <= 8'h00;
      rsh_r <= 8'h00;
    end else if (i_ce) begin
      if (start && !txe_r) begin
        sh_r <= txbuf_r;
      end else if (shift_ev) begin
        sh_r <= {sh_r[6:0], 1'b0};
      end
      rsh_r <= rx_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rxd_r <= 8'h00;
      disc_r <= 1'b0;
    end else if (i_ce) begin
      if (rxf_set) begin
        rxd_r <= rx_next;
      end
      if (start) begin
        disc_r <= 1'b0;
      end else if (ovr_set) begin
        disc_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sck_r <= 1'b0;
      ssp_r <= 1'b1;
      sckp_r <= 1'b0;
    end else if (i_ce) begin
      ssp_r <= i_ss_n;
      sckp_r <= sck_act;
      if (!(mst && en) || abort) begin
        sck_r <= clock_polarity_bit;
      end else if (m_edge) begin
        sck_r <= !sck_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn || !i_ce);

  a_ack_single_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_data_write_txie: assert property (wr_dat |=> !ctl_r[SMP_CTL_TXIE])
    else $error("data write left transmit interrupt enable set");
  a_rx_capture: assert property (rxf_set |=> rxf_r && rxd_r == $past(rx_next))
    else $error("receive data or full flag not updated at transfer end");
  a_rxf_kept: assert property (rxf_r && rd_dat && !rarm_r |=> rxf_r)
    else $error("full flag cleared without status read first");
  a_miso_release: assert property (i_ss_n || mst |-> !o_miso_oe)
    else $error("MISO driven while not a selected slave");
  a_sck_slave_in: assert property (!mst |-> !o_sck_oe)
    else $error("slave drove the serial clock");
  a_mode_fault_flag_master: assert property (m_fault |=> mode_fault_flag_r && !en && txe_r && !act)
    else $error("master mode fault effects missing");
  a_start_latency: assert property (mst && en && !act && !txe_r |-> ##[0:128] (act || !en || !mst))
    else $error("master transfer start exceeded one bit time");
  a_ovr_discard: assert property (ovr_set |=> ovr_r && disc_r)
    else $error("overflow not flagged at bit one capture");

endmodule
`default_nettype wire

// [tb/smp_far_end.sv]
// Far-side model of the serial link: slave while the port masters, master while it is a slave.
`timescale 1ns/1ps
`default_nettype none
module smp_far_end (
  // Clock and role
  input wire logic i_clk,
  input wire logic i_slv,
  input wire logic i_clock_polarity_bit,
  input wire logic i_clock_phase_bit,
  // Wire levels
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  // Driven lines
  output logic o_sck,
  output logic o_mosi,
  output logic o_miso,
  output logic o_ss_n
);
  logic ob = 1'h0;
  logic busy = 1'h0;
  logic [7:0] sr = 8'h00;
  logic [7:0] rx = 8'h00;
  // A released MISO shows the inverse of its bit, so a stale copy cannot pass.
  assign o_miso = (i_clock_phase_bit ? ob : sr[7]) ^ !i_slv;
  initial begin
    o_sck = 1'h0;
    o_mosi = 1'h0;
    o_ss_n = 1'h1;
  end
  always @(posedge i_clk) begin
    if (!busy) begin
      o_sck <= i_clock_polarity_bit;
    end
  end
  // The slave answers each clock edge in the same step, so it keeps up when the clock toggles every cycle.
  always @(i_sck) begin
    if (i_slv && ((i_sck != i_clock_polarity_bit) ^ i_clock_phase_bit)) begin
      rx <= {rx[6:0], i_mosi};
    end
    if (i_slv && !((i_sck != i_clock_polarity_bit) ^ i_clock_phase_bit)) begin
      ob <= sr[7];
      sr <= {sr[6:0], 1'h0};
    end
  end
  task automatic load(input logic [7:0] b);
    sr <= b;
  endtask
  task automatic sel(input logic v);
    o_ss_n <= v;
  endtask
  // One byte as master, h bus cycles per half bit.
  task automatic xfer(input logic [7:0] tx, input int h, output logic [7:0] got);
    busy = 1'h1;
    o_ss_n <= 1'h0;
    repeat (h) @(posedge i_clk);
    for (int i = 7; i >= 0; i--) begin
      if (!i_clock_phase_bit) begin
        o_mosi <= tx[i];
        repeat (h) @(posedge i_clk);
        got[i] = i_miso;
      end
      o_sck <= !i_clock_polarity_bit;
      if (i_clock_phase_bit) begin
        o_mosi <= tx[i];
      end
      repeat (h) @(posedge i_clk);
      if (i_clock_phase_bit) begin
        got[i] = i_miso;
      end
      o_sck <= i_clock_polarity_bit;
      if (i_clock_phase_bit) begin
        repeat (h) @(posedge i_clk);
      end
    end
    repeat (h) @(posedge i_clk);
    o_ss_n <= 1'h1;
    o_mosi <= !o_mosi;
    @(posedge i_clk);
    busy = 1'h0;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the serial port: registers, master and slave transfers.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smp_pkg::*;
  localparam logic [7:0] A_CTL = {SMP_IDX_CTL, 2'h0};
  localparam logic [7:0] A_STS = {SMP_IDX_STS, 2'h0};
  localparam logic [7:0] A_DAT = {SMP_IDX_DAT, 2'h0};
  localparam logic [7:0] A_UNM = 8'h4C;
  logic clk = 1'h0, resetn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic p_slv = 1'h1, p_clock_polarity_bit = 1'h0, p_clock_phase_bit = 1'h0;
  logic [7:0] adr = 8'h00, s, got;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, d_sck, d_sck_oe, d_mosi, d_mosi_oe, d_miso, d_miso_oe, f_sck, f_mosi, f_miso, f_ss_n;
  int failures = 0, tests_run = 0, cyc_n = 0;
  wire logic sck_w = d_sck_oe ? d_sck : f_sck;
  wire logic mosi_w = d_mosi_oe ? d_mosi : f_mosi;
  wire logic miso_w = d_miso_oe ? d_miso : f_miso;
  always #50 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;
  smp_port uut (.i_clk(clk), .i_resetn(resetn), .i_ce(1'h1), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sck(sck_w),
    .o_sck(d_sck), .o_sck_oe(d_sck_oe), .i_mosi(mosi_w), .o_mosi(d_mosi), .o_mosi_oe(d_mosi_oe),
    .i_miso(miso_w), .o_miso(d_miso), .o_miso_oe(d_miso_oe), .i_ss_n(f_ss_n));
  smp_far_end far (.i_clk(clk), .i_slv(p_slv), .i_clock_polarity_bit(p_clock_polarity_bit), .i_clock_phase_bit(p_clock_phase_bit), .i_sck(sck_w),
    .i_mosi(mosi_w), .i_miso(miso_w), .o_sck(f_sck), .o_mosi(f_mosi), .o_miso(f_miso), .o_ss_n(f_ss_n));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] v);
    tests_run++;
    if (v !== e) begin
      $display("FAIL %s expected %h seen %h", what, e, v);
      failures++;
    end
  endtask
  // Classic cycle: request held until ack is sampled high, then released.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    r = rdat[7:0];
    chk("wb_ack", 8'h01, {7'h0, ack});
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [7:0] v;
    wb(1'h0, a, 8'h00, v);
    chk(w, e, v);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    wb(1'h1, a, d, v);
  endtask
  task automatic wait_flag(input int b, output logic [7:0] v);
    int n;
    n = 0;
    do begin
      wb(1'h0, A_STS, 8'h00, v);
      n++;
    end while (v[b] !== 1'h1 && n < 500);
  endtask
  // One master transfer; d: 0 leaves the byte unread, 1 drains it, 2 drains and checks data.
  task automatic mx(input logic [7:0] cfg, input logic [1:0] r, input logic [7:0] tx, input logic [7:0] ptx,
                    input int d);
    int t;
    int h;
    logic [7:0] v;
    h = 1 << (2 * r);
    wr(A_CTL, {2'h0, 1'h1, p_clock_polarity_bit, p_clock_phase_bit, 3'h0});
    p_slv <= 1'h1;
    p_clock_polarity_bit <= cfg[SMP_CTL_CLOCK_POLARITY_BIT];
    p_clock_phase_bit <= cfg[SMP_CTL_CLOCK_PHASE_BIT];
    wr(A_CTL, cfg);
    wr(A_STS, {6'h0, r});
    wr(A_CTL, cfg | 8'h02);
    far.load(ptx);
    wr(A_DAT, tx);
    t = cyc_n;
    rd(A_CTL, (cfg | 8'h02) & 8'hBA, "ctl_txie");
    wait_flag(SMP_STS_RXF, v);
    t = cyc_n - t;
    chk("full_time", 8'h01, {7'h0, (t >= 16 * h) && (t <= 18 * h + 12)});
    chk("sts_full", 8'h88 | {6'h0, r}, v);
    if (d > 0) begin
      wb(1'h0, A_DAT, 8'h00, v);
      if (d > 1) chk("rx_data", ptx, v);
      if (d > 1) chk("far_rx", tx, far.rx);
      rd(A_STS, 8'h08 | {6'h0, r}, "sts_clr");
    end
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    rd(A_CTL, 8'h28, "ctl_rst");
    rd(A_STS, 8'h08, "sts_rst");
    rd(A_DAT, 8'h00, "dat_rst");
    wr(A_UNM, 8'hFF);
    rd(A_UNM, 8'h00, "unmapped");
    rd(A_CTL, 8'h28, "ctl_kept");
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      mx(8'hE1 | {3'h0, i[1:0], 3'h0}, (i == 4) ? 2'h1 : i[1:0], 8'hA5 + i[7:0], 8'h3C ^ i[7:0], 2);
    end
    mx(8'hE1, 2'h1, 8'h11, 8'h77, 0);
    far.load(8'h99);
    wr(A_DAT, 8'h22);
    wait_flag(SMP_STS_OVR, s);
    repeat (80) @(posedge clk);
    rd(A_STS, 8'hA9, "sts_ovr");
    rd(A_DAT, 8'h77, "dat_kept");
    rd(A_STS, 8'h09, "ovr_clr");
    wr(A_STS, 8'h05);
    far.sel(1'h0);
    repeat (4) @(posedge clk);
    rd(A_STS, 8'h1D, "sts_mode_fault_flag");
    rd(A_CTL, 8'hA0, "ctl_off");
    far.sel(1'h1);
    repeat (4) @(posedge clk);
    rd(A_STS, 8'h1D, "sts_arm");
    wr(A_CTL, 8'h20);
    rd(A_STS, 8'h0D, "mode_fault_flag_clr");
    $display("test master done");
    wr(A_STS, 8'h01);
    for (int c = 0; c < 2; c++) begin
      wr(A_CTL, {4'h0, p_clock_phase_bit, 3'h0});
      p_slv <= 1'h0;
      p_clock_phase_bit <= c[0];
      wr(A_CTL, {4'h0, c[0], 3'h0});
      wr(A_CTL, {4'h0, c[0], 3'h2});
      wr(A_DAT, 8'h6C);
      chk("sck_oe", 8'h00, {7'h0, d_sck_oe});
      fork
        far.xfer(8'hB1, 4, got);
        begin
          repeat (30) @(posedge clk);
          chk("miso_on", 8'h01, {7'h0, d_miso_oe});
          wr(A_DAT, 8'h93);
        end
      join
      chk("far_rx", 8'h6C, got);
      chk("miso_off", 8'h00, {7'h0, d_miso_oe});
      rd(A_STS, 8'h81, "slv_sts");
      rd(A_DAT, 8'hB1, "slv_rx");
      far.xfer(8'h4E, 4, got);
      chk("far_next", 8'h93, got);
      rd(A_STS, 8'h89, "slv_sts2");
      rd(A_DAT, 8'h4E, "slv_rx2");
      far.xfer(8'hD2, 1, got);
      rd(A_STS, 8'h89, "fast_sts");
      rd(A_DAT, 8'hD2, "fast_rx");
    end
    $display("test slave done");
    close_out;
  end
endmodule
`default_nettype wire
